//--- rtl/rio_defines.svh
// Constants of the interrupt output logic: offsets, fields, resets, timing.
`ifndef RIO_DEFINES_SVH
`define RIO_DEFINES_SVH

// System clock rate in hertz.
`define RIO_CLK_HZ 100000000

// Register indices; byte address is four times the index.
`define RIO_IDX_FLAGS 4'h0
`define RIO_IDX_CTRL 4'h6

// Event flags register bit positions.
`define RIO_B_WDF 7
`define RIO_B_AF 6
`define RIO_B_PF 5
`define RIO_B_OSC_STOP_FLAG 4
`define RIO_B_BPF 3
`define RIO_B_CAL 2
`define RIO_B_W 1

// Interrupt control register bit positions.
`define RIO_B_WIE 7
`define RIO_B_AIE 6
`define RIO_B_PFE 5
`define RIO_B_SQUARE_WAVE_ENABLE 4
`define RIO_B_HL 3
`define RIO_B_PL 2
`define RIO_B_SQ1 1
`define RIO_B_SQ0 0

// Reset values: flags clear, control {WATCHDOG_IRQ_ENABLE,ALARM_IRQ_ENABLE,POWERFAIL_IRQ_ENABLE,HL,PL} with HL set.
`define RIO_FLAGS_RST 3'h0
`define RIO_CTL_RST 5'h02
`define RIO_NV_FACTORY 3'h0

// Pulse width in milliseconds and its cycle count (longest, rounded down).
`define RIO_PULSE_MS 200
`define RIO_PULSE_CYC (`RIO_PULSE_MS * (`RIO_CLK_HZ / 1000))

// Wave frequencies in hertz and half periods in cycles.
`define RIO_F_1HZ 1
`define RIO_F_512HZ 512
`define RIO_F_4KHZ 4096
`define RIO_F_32KHZ 32768
`define RIO_HALF_1HZ (`RIO_CLK_HZ / (2 * `RIO_F_1HZ))
`define RIO_HALF_512HZ (`RIO_CLK_HZ / (2 * `RIO_F_512HZ))
`define RIO_HALF_4KHZ (`RIO_CLK_HZ / (2 * `RIO_F_4KHZ))
`define RIO_HALF_32KHZ (`RIO_CLK_HZ / (2 * `RIO_F_32KHZ))

`endif

//--- rtl/rio_nvbits.sv
// Nonvolatile holder for the square wave enable and frequency select bits.
`timescale 1ns/1ns
`default_nettype none
`include "rio_defines.svh"

module rio_nvbits
  import rio_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       nv_erase_i,
  input  wire logic       wr_i,
  input  wire logic [2:0] wdata_i,
  output logic      [2:0] q_o
);

  rio_nv_s nv_q;
  rio_nv_s nv_d;

  // Power-up reset does not touch these bits; only a factory erase does.
  always_comb begin
    nv_d = nv_q;
    if (nv_erase_i) begin
      nv_d = `RIO_NV_FACTORY;
    end else if (wr_i) begin
      nv_d = wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    nv_q <= nv_d;
  end

  assign q_o = nv_q;

endmodule : rio_nvbits
`default_nettype wire

//--- rtl/rio_pkg.sv
// Types shared by the interrupt output logic modules.
package rio_pkg;

  // Pulse timer states.
  typedef enum logic {
    PS_IDLE   = 1'b0,
    PS_ACTIVE = 1'b1
  } rio_pulse_e;

  // Source events, one-cycle pulses from the monitors.
  typedef struct packed {
    logic wdt;
    logic alarm;
    logic pfail;
  } rio_evt_s;

  // Nonvolatile wave settings.
  typedef struct packed {
    logic       square_wave_enable;
    logic [1:0] sq;
  } rio_nv_s;

  // State of the top module, apart from the nonvolatile wave bits held in rio_nvbits.
  typedef struct packed {
    logic [2:0]  flags;
    logic        wr_en;
    logic        cal;
    logic [4:0]  ctl;
    logic        waitreq;
    logic [7:0]  rdata;
    logic [2:0]  snap;
    logic        act_prev;
    rio_pulse_e  pst;
    logic [31:0] pcnt;
    logic [31:0] wcnt;
    logic        wave;
    logic        pin;
    logic        pin_oe;
  } rio_state_s;

endpackage : rio_pkg

//--- rtl/rio_top.sv
// Interrupt output logic of the clock companion, with Avalon-MM registers.
//
// Functional notes
// - Interrupt needs set flag and its enable.
// - Watchdog, alarm, power fail set their flags.
// - Pulse mode drives pin about 200 ms.
// - Level mode holds pin until flags read.
// - Pulse select bit: one pulse, zero level.
// - Polarity one push-pull high, zero open-drain low.
// - Active-high drive only above switchover threshold.
// - No interrupts while on backup power.
// - Interrupts valid only after power-up recall.
// - Disabled source only sets its flag.
// - Square wave enable replaces interrupt output.
// - Calibration bit forces 512 Hz tone.
// - Two select bits pick wave rate.
// - Wave enable and select bits are nonvolatile.
// - Flags read clears flags, releases level pin.
// - Flags read during pulse ends it early.
// - Flags register loads zero on power-up.
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
`include "rio_defines.svh"

module rio_top
  import rio_pkg::*;
#(
  parameter int unsigned PULSE_CYC  = `RIO_PULSE_CYC,
  parameter int unsigned HALF_1HZ   = `RIO_HALF_1HZ,
  parameter int unsigned HALF_512HZ = `RIO_HALF_512HZ,
  parameter int unsigned HALF_4KHZ  = `RIO_HALF_4KHZ
)
(
  input  wire logic        clk_sys_i,
  input  wire logic        srst_i,
  // Avalon-MM slave, byte addresses.
  input  wire logic [5:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [3:0]  avs_byteenable_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Source events, one cycle each.
  input  wire logic        wdt_timeout_i,
  input  wire logic        alarm_match_i,
  input  wire logic        power_fail_i,
  // Status from the power monitor and recall engine.
  input  wire logic        vcc_above_switch_i,
  input  wire logic        recall_done_i,
  input  wire logic        osc_stop_flag_i,
  input  wire logic        backup_fail_flag_i,
  // Factory erase of the nonvolatile wave settings.
  input  wire logic        nv_erase_i,
  // Interrupt pin as output and output enable.
  output logic             int_o,
  output logic             int_oe_o
);

  localparam logic [31:0] HALF_32KHZ = 32'(`RIO_HALF_32KHZ);

  rio_state_s q;
  rio_state_s d;
  rio_evt_s   evt;
  logic [2:0] nv_q;
  logic       nv_wr;

  // Half period for the selected square wave rate.
  function automatic logic [31:0] sel_half(input logic [1:0] sel);
    case (sel)
      2'b00:   sel_half = 32'(HALF_1HZ);
      2'b01:   sel_half = 32'(HALF_512HZ);
      2'b10:   sel_half = 32'(HALF_4KHZ);
      default: sel_half = HALF_32KHZ;
    endcase
  endfunction : sel_half

  // True when the byte address selects the given register index.
  function automatic logic hit(input logic [5:0] a, input logic [3:0] idx);
    hit = (a == {idx, 2'b00});
  endfunction : hit

  assign evt = '{wdt: wdt_timeout_i, alarm: alarm_match_i,
                 pfail: power_fail_i};

  rio_nvbits u_nv (
    .clk_sys_i  (clk_sys_i),
    .nv_erase_i (nv_erase_i),
    .wr_i       (nv_wr),
    .wdata_i    ({avs_writedata_i[`RIO_B_SQUARE_WAVE_ENABLE],
                  avs_writedata_i[`RIO_B_SQ1],
                  avs_writedata_i[`RIO_B_SQ0]}),
    .q_o        (nv_q)
  );

  // Bus decode terms used by the next-state logic.
  logic       req;
  logic       done;
  logic       hit_f;
  logic       hit_c;
  logic       wr;
  logic       clr;
  logic [7:0] rd_mux;

  always_comb begin
    req   = avs_read_i | avs_write_i;
    done  = req & ~q.waitreq;
    hit_f = hit(avs_address_i, `RIO_IDX_FLAGS);
    hit_c = hit(avs_address_i, `RIO_IDX_CTRL);
    wr    = done & avs_write_i & avs_byteenable_i[0];
    clr   = done & avs_read_i & hit_f;
    nv_wr = wr & hit_c;
  end

  // Read multiplexer; unmapped addresses read as zero.
  always_comb begin
    rd_mux = 8'h00;
    if (hit_f) begin
      rd_mux[`RIO_B_WDF]  = q.flags[2];
      rd_mux[`RIO_B_AF]   = q.flags[1];
      rd_mux[`RIO_B_PF]   = q.flags[0];
      rd_mux[`RIO_B_OSC_STOP_FLAG] = osc_stop_flag_i;
      rd_mux[`RIO_B_BPF]  = backup_fail_flag_i;
      rd_mux[`RIO_B_CAL]  = q.cal;
      rd_mux[`RIO_B_W]    = q.wr_en;
    end else if (hit_c) begin
      rd_mux[`RIO_B_WIE]  = q.ctl[4];
      rd_mux[`RIO_B_AIE]  = q.ctl[3];
      rd_mux[`RIO_B_PFE]  = q.ctl[2];
      rd_mux[`RIO_B_SQUARE_WAVE_ENABLE] = nv_q[2];
      rd_mux[`RIO_B_HL]   = q.ctl[1];
      rd_mux[`RIO_B_PL]   = q.ctl[0];
      rd_mux[`RIO_B_SQ1]  = nv_q[1];
      rd_mux[`RIO_B_SQ0]  = nv_q[0];
    end
  end

  // Interrupt qualification and pin drive terms.
  logic        pwr_ok;
  logic        active;
  logic        irq_lvl;
  logic        drive_on;
  logic        drive_lvl;
  logic [31:0] half;

  always_comb begin
    // Interrupts exist only on main power after recall.
    pwr_ok = vcc_above_switch_i & recall_done_i;
    active = pwr_ok & (|(q.flags & q.ctl[4:2]));
    // Pulse or level style picked by the pulse select bit.
    irq_lvl = q.ctl[0] ? (q.pst == PS_ACTIVE) : active;
    half = q.cal ? 32'(HALF_512HZ) : sel_half(nv_q[1:0]);
    drive_on  = 1'b0;
    drive_lvl = 1'b0;
    // Calibration beats square wave, which beats the interrupt.
    if (!pwr_ok) begin
      drive_on = 1'b0;
    end else if (q.cal) begin
      drive_on  = 1'b1;
      drive_lvl = q.wave;
    end else if (nv_q[2]) begin
      drive_on  = 1'b1;
      drive_lvl = q.wave;
    end else if (|q.ctl[4:2]) begin
      drive_on  = 1'b1;
      drive_lvl = irq_lvl;
    end
  end

  // Next state: bus handshake, flags, control, pulse timer, wave, pin.
  always_comb begin
    d = q;
    // One wait cycle, then the access completes with waitrequest low.
    d.waitreq = 1'b1;
    if (req && q.waitreq) begin
      d.waitreq = 1'b0;
      d.rdata   = avs_read_i ? rd_mux : q.rdata;
      d.snap    = (avs_read_i && hit_f) ? q.flags : 3'h0;
    end
    // Only flags already shown to the host are cleared, so a flag that
    // rose during the wait cycle or at the clearing edge survives.
    d.flags = (q.flags & ~(clr ? q.snap : 3'h0)) | evt;
    if (|evt) begin
      d.flags = d.flags | evt;
    end
    // Flags register writes: W gates CAL.
    if (wr && hit_f) begin
      d.wr_en = avs_writedata_i[`RIO_B_W];
      if (q.wr_en) begin
        d.cal = avs_writedata_i[`RIO_B_CAL];
      end
    end
    if (wr && hit_c) begin
      d.ctl = {avs_writedata_i[`RIO_B_WIE], avs_writedata_i[`RIO_B_AIE],
               avs_writedata_i[`RIO_B_PFE], avs_writedata_i[`RIO_B_HL],
               avs_writedata_i[`RIO_B_PL]};
    end
    // Pulse timer starts on a rising qualified interrupt.
    d.act_prev = active;
    case (q.pst)
      PS_IDLE: begin
        if (active && !q.act_prev && q.ctl[0]) begin
          d.pst  = PS_ACTIVE;
          d.pcnt = 32'h0;
        end
      end
      PS_ACTIVE: begin
        if (clr || !pwr_ok || (q.pcnt >= 32'(PULSE_CYC) - 32'h1)) begin
          d.pst = PS_IDLE;
        end else begin
          d.pcnt = q.pcnt + 32'h1;
        end
      end
      default: begin
        d.pst = PS_IDLE;
      end
    endcase
    // Free-running wave divider shared by tone and square wave.
    if (q.wcnt >= half - 32'h1) begin
      d.wcnt = 32'h0;
      d.wave = ~q.wave;
    end else begin
      d.wcnt = q.wcnt + 32'h1;
    end
    // Pin drive style follows the polarity bit.
    if (!drive_on) begin
      d.pin    = 1'b0;
      d.pin_oe = 1'b0;
    end else if (q.ctl[1]) begin
      d.pin    = drive_lvl;
      d.pin_oe = 1'b1;
    end else begin
      d.pin    = 1'b0;
      d.pin_oe = drive_lvl;
    end
  end

  // State register; power-up reset clears flags and timers.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      q          <= '0;
      q.flags    <= `RIO_FLAGS_RST;
      q.ctl      <= `RIO_CTL_RST;
      q.waitreq  <= 1'b1;
      q.pst      <= PS_IDLE;
    end else begin
      q <= d;
    end
  end

  assign avs_readdata_o    = {24'h0, q.rdata};
  assign avs_waitrequest_o = q.waitreq;
  assign int_o             = q.pin;
  assign int_oe_o          = q.pin_oe;

endmodule : rio_top
`default_nettype wire

//--- verification/rio_host_model.sv
// Host side model: pull-up on the interrupt line and the power-up blanking.
`timescale 1ns/1ns
`default_nettype none
module rio_host_model #(
  parameter int BLANK = 8
) (
  input  wire logic clk_sys_i,
  input  wire logic recall_done_i,
  input  wire logic int_i,
  input  wire logic int_oe_i,
  output logic      pin_o,
  output logic      seen_o
);
  // Starts from zero at power-up, so blanking also runs when recall is
  // already complete at time zero and the count never stays unknown.
  logic [7:0] blank_q = 8'h0;
  // Released line floats up to the pull-up, so open drain reads high.
  assign pin_o = int_oe_i ? int_i : 1'b1;
  // Pin activity is only believed once the blanking time has run out.
  always_ff @(posedge clk_sys_i) begin
    if (!recall_done_i) blank_q <= 8'h0;
    else if (blank_q < 8'(BLANK)) blank_q <= blank_q + 8'h1;
  end
  assign seen_o = (blank_q == 8'(BLANK)) && int_oe_i;
endmodule : rio_host_model
`default_nettype wire

//--- verification/rio_top_chk.sv
// Concurrent checks on the ports of the interrupt output logic.
`timescale 1ns/1ns
`default_nettype none
module rio_top_chk
  import rio_pkg::*;
#(parameter int unsigned PULSE_CYC = 20)
(
  input wire logic        clk_sys_i,
  input wire logic        srst_i,
  input wire logic [5:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        vcc_above_switch_i,
  input wire logic        recall_done_i,
  input wire logic        nv_erase_i,
  input wire logic        int_o,
  input wire logic        int_oe_o
);
  localparam int P_MAX = PULSE_CYC + 4;
  logic [7:0] sh_q;
  logic       rd;
  logic       wr;
  // Completed flags read and completed control write.
  assign rd = avs_read_i && !avs_waitrequest_o && avs_address_i == 6'h00;
  assign wr = avs_write_i && !avs_waitrequest_o && avs_address_i == 6'h18
              && avs_byteenable_i[0];
  // Control shadow; wave bits survive reset like the nonvolatile store.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) sh_q <= {3'h0, sh_q[4], 2'h2, sh_q[1:0]};
    else if (wr) sh_q <= avs_writedata_i[7:0];
    if (nv_erase_i) begin
      sh_q[4] <= 1'b0;
      sh_q[1:0] <= 2'h0;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  a_reset_state: assert property (disable iff (1'b0)
    srst_i |=> avs_waitrequest_o && !int_oe_o && avs_readdata_o == 32'h0)
    else $error("reset state wrong");
  a_backup_quiet: assert property (
    (!vcc_above_switch_i)[*3] |-> !int_oe_o) else $error("pin on backup");
  a_recall_quiet: assert property (
    (!recall_done_i)[*3] |-> !int_oe_o) else $error("pin before recall");
  a_high_needs_vcc: assert property (
    int_o && int_oe_o |-> $past(vcc_above_switch_i))
    else $error("high drive without supply");
  a_level_hold: assert property (
    sh_q[4:2] == 3'b010 && vcc_above_switch_i && recall_done_i && int_o
    && int_oe_o && !rd && !$past(rd) |=> int_o) else $error("level dropped");
  a_pulse_ends: assert property (
    $rose(int_o) && sh_q[4:2] == 3'b011 |-> ##[1:P_MAX] !int_o)
    else $error("pulse too long");
  a_hiz_idle: assert property (
    (sh_q[7:4] == 4'h0)[*3] |-> !int_oe_o) else $error("idle pin driven");
  a_od_low: assert property (
    (!sh_q[3])[*2] |-> !int_o) else $error("open drain drives high");
  c_pulse: cover property ($rose(int_o) && sh_q[2]);
  c_read: cover property (rd);
  c_od: cover property (int_oe_o && !sh_q[3]);
endmodule : rio_top_chk
bind rio_top rio_top_chk #(.PULSE_CYC(PULSE_CYC)) u_chk (.clk_sys_i,
  .srst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_byteenable_i,
  .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
  .vcc_above_switch_i, .recall_done_i, .nv_erase_i, .int_o, .int_oe_o);
`default_nettype wire

//--- verification/rio_top_tb.sv
// Self-checking bench for the interrupt output logic top module.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin \
  mismatches++; $display("unexpected %s exp %0h got %0h", n, e, s); end end
module rio_top_tb;
  import rio_pkg::*;
  localparam int PC = 20;
  logic clk = 0, srst = 1, rd = 0, wr = 0, vcc = 1, rcl = 1;
  logic osc = 0, bpf = 0, ers = 1, io, ioe, wq, pin, seen;
  logic [5:0] adr = 0;
  logic [3:0] be = 4'h1;
  logic [31:0] wd = 0, rdat, q;
  logic [2:0] ev = 0, ef = 0, m;
  int mismatches = 0, comparisons = 0, n;
  int hw[4] = '{16, 8, 4, 1525};
  // Clock of 100 MHz.
  always #5 clk = !clk;
  rio_top #(.PULSE_CYC(PC), .HALF_1HZ(16), .HALF_512HZ(8), .HALF_4KHZ(4))
  u_dut (.clk_sys_i(clk), .srst_i(srst), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_byteenable_i(be),
    .avs_writedata_i(wd), .avs_readdata_o(rdat), .avs_waitrequest_o(wq),
    .wdt_timeout_i(ev[2]), .alarm_match_i(ev[1]), .power_fail_i(ev[0]),
    .vcc_above_switch_i(vcc), .recall_done_i(rcl), .osc_stop_flag_i(osc),
    .backup_fail_flag_i(bpf), .nv_erase_i(ers), .int_o(io), .int_oe_o(ioe));
  rio_host_model u_host (.clk_sys_i(clk), .recall_done_i(rcl), .int_i(io),
    .int_oe_i(ioe), .pin_o(pin), .seen_o(seen));
  task give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  // One bus access; the request stands until waitrequest is seen low.
  task bus(input logic w, input logic [5:0] a, input logic [7:0] d);
    int k;
    @(posedge clk);
    adr <= a; wd <= {24'h0, d}; wr <= w; rd <= !w; k = 0;
    do begin @(posedge clk); k++; end while (wq !== 1'b0 && k < 50);
    q = rdat;
    if (k >= 50) mismatches++;
    rd <= 1'b0; wr <= 1'b0;
  endtask : bus
  task rdc(input logic [5:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h0);
    `CHK("readdata", {24'h0, e}, q)
  endtask : rdc
  // The model forgets its flags once they have been read.
  task rflags;
    rdc(6'h00, {ef, osc, bpf, 3'h0});
    ef = 3'h0;
  endtask : rflags
  task evt(input logic [2:0] v);
    @(posedge clk); ev <= v; @(posedge clk); ev <= 3'h0; ef = ef | v;
  endtask : evt
  task tick(input int k); repeat (k) @(posedge clk); endtask : tick
  // Skips a partial half period, then measures a full one.
  task half(input int e);
    logic p;
    p = pin; n = 0;
    while (pin === p && n < 4000) begin @(posedge clk); n++; end
    p = pin; n = 0;
    while (pin === p && n < 4000) begin @(posedge clk); n++; end
    `CHK("half period", e, n)
  endtask : half
  initial begin
    tick(60000);
    mismatches++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'hd6a679af));
    osc = 1'($urandom); bpf = 1'($urandom); m = 3'($urandom_range(7, 1));
    tick(20); srst <= 1'b0; ers <= 1'b0;
    rflags();
    rdc(6'h18, 8'h08);
    rdc(6'h3c, 8'h00);
    be <= 4'h0; bus(1'b1, 6'h18, 8'he0); be <= 4'h1;
    rdc(6'h18, 8'h08);
    // Disabled sources only set flags; a read racing a new event keeps it.
    evt(m); tick(3);
    `CHK("oe", 1'b0, ioe)
    `CHK("pin", 1'b1, pin)
    fork rflags(); begin tick(2); ev <= 3'b010; tick(1); ev <= 3'h0; end join
    ef = 3'b010;
    rflags();
    // Level mode, push-pull, then supply and recall gating.
    bus(1'b1, 6'h18, 8'he8); evt(m); tick(3);
    `CHK("pin", 1'b1, pin)
    `CHK("seen", 1'b1, seen)
    tick(20);
    `CHK("pin", 1'b1, pin)
    vcc <= 1'b0; tick(3);
    `CHK("oe", 1'b0, ioe)
    vcc <= 1'b1; rcl <= 1'b0; tick(3);
    `CHK("oe", 1'b0, ioe)
    rcl <= 1'b1; tick(3);
    rflags(); tick(3);
    `CHK("pin", 1'b0, pin)
    // Open drain pulls low while active.
    bus(1'b1, 6'h18, 8'he0); evt(3'b100); tick(3);
    `CHK("pin", 1'b0, pin)
    rflags(); tick(3);
    `CHK("pin", 1'b1, pin)
    // Pulse mode: full width, then a read cuts a second pulse short.
    bus(1'b1, 6'h18, 8'hec); evt(3'b001); n = 0;
    while (pin !== 1'b1 && n < 10) begin @(posedge clk); n++; end
    n = 0;
    while (pin === 1'b1 && n < 100) begin @(posedge clk); n++; end
    `CHK("pulse width", PC, n)
    rflags();
    evt(3'b001); tick(5);
    `CHK("pin", 1'b1, pin)
    rflags(); tick(3);
    `CHK("pin", 1'b0, pin)
    // Square wave at each rate, then the calibration tone on top of it.
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 6'h18, 8'h18 | 8'(i)); half(hw[i]);
    end
    bus(1'b1, 6'h00, 8'h02); bus(1'b1, 6'h00, 8'h06);
    half(8);
    bus(1'b1, 6'h00, 8'h02); bus(1'b1, 6'h00, 8'h00);
    srst <= 1'b1; tick(2); srst <= 1'b0;
    rdc(6'h18, 8'h1b);
    ers <= 1'b1; tick(1); ers <= 1'b0;
    rdc(6'h18, 8'h08);
    give_verdict();
  end
endmodule : rio_top_tb
`default_nettype wire
